// *** core/pmon_cfg.svh ***
// event codes, masks and sizing constants for the event qualifier
`ifndef PMON_CFG_SVH
`define PMON_CFG_SVH
`define EVT_UOPS 8'hc2
`define EVT_FLUSH 8'hc3
`define EVT_BRANCH 8'hc4
`define MSK_UOP_ROM 8'h01
`define MSK_UOP_ALL 8'h10
`define MSK_FL_CODE 8'h01
`define MSK_FL_ORDER 8'h02
`define MSK_FL_FP 8'h04
`define MSK_FL_ANY 8'h08
`define MSK_BR_ALL 8'h00
`define MSK_BR_JCC 8'h7e
`define MSK_BR_FAR 8'hbf
`define MSK_BR_IND 8'heb
`define RET_LANES 4
`define CNT_W 48
`define REGION_LSB 10
`define ADDR_W 32
`define CNT_RST 48'h000000000000
`endif

// *** core/pmon_pkg.sv ***
// types shared by the event qualifier files
`default_nettype none
package pmon_pkg;
  typedef enum logic [3:0] {
    SEL_NONE, SEL_UOP_ROM, SEL_UOP_ALL, SEL_FL_CODE, SEL_FL_ORDER,
    SEL_FL_FP, SEL_FL_ANY, SEL_BR_ALL, SEL_BR_JCC, SEL_BR_FAR, SEL_BR_IND
  } sel_e;
  typedef enum logic [1:0] {
    FL_IDLE, FL_DRAIN, FL_ASSIST
  } flush_state_e;
endpackage : pmon_pkg
`default_nettype wire

// *** core/lane_popcount.sv ***
// counts set bits of a qualified lane vector
`timescale 1ns/1ps
`include "pmon_cfg.svh"
`default_nettype none
module lane_popcount (
  input wire logic [`RET_LANES-1:0] i_bits,
  output logic [2:0] o_count
);
  always_comb begin
    o_count = 3'h0;
    for (int k = 0; k < `RET_LANES; k++) begin
      o_count = o_count + {2'h0, i_bits[k]};
    end
  end
endmodule : lane_popcount
`default_nettype wire

// *** core/retire_flush_event_counter.sv ***
// event qualifier and counter for retirement, flush and branch events
//
// Overview of operation
// RL1: code c2/01 counts retired micro-ops sourced by the microcode rom.
// RL2: code c2/10 counts every retired micro-op.
// RL3: flush mask 01 counts flushes from stores into code regions.
// RL4: flush mask 02 counts load-ordering flushes.
// RL5: flush mask 04 counts floating-point assist flushes.
// RL6: flush mask 08 counts every flush, any cause.
// RL7: any-cause count need not equal the sum of specific causes.
// RL8: code-write detection compares stores to fetch at 1K regions.
// RL9: after code-write flush, drain stores before front-end restart.
// RL10: fp result needing help flushes, then fetches an assist sequence; code fetches it only from FL_IDLE with no code-write hazard.
// RL11: snoop on completed younger load with older pending flushes.
// RL12: no ordering flush when no older load is outstanding.
// RL13: code c4/00 counts every retired branch.
// RL14: branch mask 7e counts retired conditional jumps.
// RL15: branch mask bf counts retired far branches.
// RL16: branch mask eb counts near indirect calls and jumps, no returns.
// RL17: several qualifying events in one cycle add several counts.
// RL18: undefined code and mask pairs select nothing; counter holds.
`timescale 1ns/1ps
`include "pmon_cfg.svh"
`default_nettype none
module retire_flush_event_counter (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_evt_code,
  input wire logic [7:0] i_evt_mask,
  input wire logic [`RET_LANES-1:0] i_uop_valid,
  input wire logic [`RET_LANES-1:0] i_uop_from_rom,
  input wire logic [`RET_LANES-1:0] i_br_valid,
  input wire logic [`RET_LANES-1:0] i_br_cond,
  input wire logic [`RET_LANES-1:0] i_br_far,
  input wire logic [`RET_LANES-1:0] i_br_near_ind,
  input wire logic [`RET_LANES-1:0] i_br_return,
  input wire logic i_store_valid,
  input wire logic [`ADDR_W-1:0] i_store_addr,
  input wire logic i_fetch_active,
  input wire logic [`ADDR_W-1:0] i_fetch_addr,
  input wire logic i_stores_pending,
  input wire logic i_snoop_hit_done_load,
  input wire logic i_older_load_pending,
  input wire logic i_fp_needs_assist,
  input wire logic i_other_flush,
  output logic o_flush,
  output logic o_frontend_restart,
  output logic o_assist_fetch,
  output logic o_replay_from_load,
  output logic [`CNT_W-1:0] o_count
);

  //////////////////////////////////////////////////////////////////////////
  // reset release
  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  //////////////////////////////////////////////////////////////////////////
  // event selection decode
  function automatic pmon_pkg::sel_e decode_sel(input logic [7:0] code,
                                                input logic [7:0] mask);
    decode_sel = pmon_pkg::SEL_NONE; // [RL18]
    case (code)
      `EVT_UOPS: begin
        if (mask == `MSK_UOP_ROM) decode_sel = pmon_pkg::SEL_UOP_ROM;
        if (mask == `MSK_UOP_ALL) decode_sel = pmon_pkg::SEL_UOP_ALL;
      end
      `EVT_FLUSH: begin
        if (mask == `MSK_FL_CODE) decode_sel = pmon_pkg::SEL_FL_CODE;
        if (mask == `MSK_FL_ORDER) decode_sel = pmon_pkg::SEL_FL_ORDER;
        if (mask == `MSK_FL_FP) decode_sel = pmon_pkg::SEL_FL_FP;
        if (mask == `MSK_FL_ANY) decode_sel = pmon_pkg::SEL_FL_ANY;
      end
      `EVT_BRANCH: begin
        if (mask == `MSK_BR_ALL) decode_sel = pmon_pkg::SEL_BR_ALL;
        if (mask == `MSK_BR_JCC) decode_sel = pmon_pkg::SEL_BR_JCC;
        if (mask == `MSK_BR_FAR) decode_sel = pmon_pkg::SEL_BR_FAR;
        if (mask == `MSK_BR_IND) decode_sel = pmon_pkg::SEL_BR_IND;
      end
      default: decode_sel = pmon_pkg::SEL_NONE;
    endcase
  endfunction : decode_sel

  pmon_pkg::sel_e sel;
  assign sel = decode_sel(i_evt_code, i_evt_mask);

  //////////////////////////////////////////////////////////////////////////
  // flush cause detection
  logic code_write_hazard;
  logic load_ordering_hazard;
  logic fp_hazard;
  logic any_flush;
  // same 1K region counts as a hit; false positives are accepted
  assign code_write_hazard = i_store_valid && i_fetch_active &&
    (i_store_addr[`ADDR_W-1:`REGION_LSB] ==
     i_fetch_addr[`ADDR_W-1:`REGION_LSB]); // [RL8]
  assign load_ordering_hazard = i_snoop_hit_done_load &&
    i_older_load_pending; // [RL11] [RL12]
  assign fp_hazard = i_fp_needs_assist; // [RL10]
  // other causes (interrupts, traps, faults) only feed the total
  assign any_flush = code_write_hazard || load_ordering_hazard ||
    fp_hazard || i_other_flush; // [RL6] [RL7]

  //////////////////////////////////////////////////////////////////////////
  // flush sequencing
  pmon_pkg::flush_state_e fl_state_r;
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      fl_state_r <= pmon_pkg::FL_IDLE;
    end else begin
      case (fl_state_r)
        pmon_pkg::FL_IDLE: begin
          if (code_write_hazard) fl_state_r <= pmon_pkg::FL_DRAIN;
          else if (fp_hazard) fl_state_r <= pmon_pkg::FL_ASSIST;
        end
        pmon_pkg::FL_DRAIN: begin
          if (!i_stores_pending) fl_state_r <= pmon_pkg::FL_IDLE; // [RL9]
        end
        pmon_pkg::FL_ASSIST: fl_state_r <= pmon_pkg::FL_IDLE; // [RL10]
        default: fl_state_r <= pmon_pkg::FL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_flush <= 1'b0;
      o_replay_from_load <= 1'b0;
      o_frontend_restart <= 1'b0;
      o_assist_fetch <= 1'b0;
    end else begin
      o_flush <= any_flush;
      o_replay_from_load <= load_ordering_hazard; // [RL11]
      // restart only once the store pipe is empty
      o_frontend_restart <= (fl_state_r == pmon_pkg::FL_DRAIN) &&
        !i_stores_pending; // [RL9]
      o_assist_fetch <= (fl_state_r == pmon_pkg::FL_ASSIST); // [RL10]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // lane qualification
  logic [`RET_LANES-1:0] qual;
  always_comb begin
    qual = '0;
    case (sel)
      pmon_pkg::SEL_UOP_ROM: qual = i_uop_valid & i_uop_from_rom; // [RL1]
      pmon_pkg::SEL_UOP_ALL: qual = i_uop_valid; // [RL2]
      pmon_pkg::SEL_FL_CODE: qual[0] = code_write_hazard; // [RL3]
      pmon_pkg::SEL_FL_ORDER: qual[0] = load_ordering_hazard; // [RL4]
      pmon_pkg::SEL_FL_FP: qual[0] = fp_hazard; // [RL5]
      pmon_pkg::SEL_FL_ANY: qual[0] = any_flush; // [RL6]
      pmon_pkg::SEL_BR_ALL: qual = i_br_valid; // [RL13]
      pmon_pkg::SEL_BR_JCC: qual = i_br_valid & i_br_cond; // [RL14]
      pmon_pkg::SEL_BR_FAR: qual = i_br_valid & i_br_far; // [RL15]
      pmon_pkg::SEL_BR_IND: qual = i_br_valid & i_br_near_ind &
        ~i_br_return; // [RL16]
      default: qual = '0; // [RL18]
    endcase
  end

  logic [2:0] inc;
  lane_popcount u_pop (
    .i_bits(qual),
    .o_count(inc)
  );

  //////////////////////////////////////////////////////////////////////////
  // counter
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      o_count <= `CNT_RST;
    end else begin
      o_count <= o_count + {{(`CNT_W-3){1'b0}}, inc}; // [RL17]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  // counts are judged one edge after the lanes that they qualify
  chk_rom_uop_count: assert property (@(posedge i_mclk) // [RL1]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_UOP_ROM) |=> o_count == $past(o_count) +
      48'($countones($past(i_uop_valid & i_uop_from_rom))))
    else $error("rom uop count wrong");
  chk_all_uop_count: assert property (@(posedge i_mclk) // [RL2] [RL17]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_UOP_ALL) |=> o_count == $past(o_count) +
      48'($countones($past(i_uop_valid))))
    else $error("uop count wrong");
  chk_uop_mask_decode: assert property (@(posedge i_mclk) // [RL18]
    disable iff (!rst_n)
    (i_evt_code == `EVT_UOPS && i_evt_mask != `MSK_UOP_ROM &&
     i_evt_mask != `MSK_UOP_ALL) |=> $stable(o_count))
    else $error("undefined uop mask counted");
  chk_code_flush_count: assert property (@(posedge i_mclk) // [RL3] [RL8]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_FL_CODE && i_store_valid && i_fetch_active &&
     i_store_addr[`ADDR_W-1:`REGION_LSB] ==
     i_fetch_addr[`ADDR_W-1:`REGION_LSB])
    |=> o_count == $past(o_count) + 1)
    else $error("code write flush not counted");
  chk_code_flush_only: assert property (@(posedge i_mclk) // [RL3]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_FL_CODE && !i_store_valid) |=> $stable(o_count))
    else $error("code write count without store");
  chk_order_flush_count: assert property (@(posedge i_mclk) // [RL4]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_FL_ORDER) |=> o_count == $past(o_count) +
      48'($past(i_snoop_hit_done_load && i_older_load_pending)))
    else $error("ordering flush count wrong");
  chk_fp_flush_count: assert property (@(posedge i_mclk) // [RL5]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_FL_FP) |=> o_count == $past(o_count) +
      48'($past(i_fp_needs_assist)))
    else $error("fp assist flush count wrong");
  chk_total_flush_count: assert property (@(posedge i_mclk) // [RL6] [RL7]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_FL_ANY && (i_fp_needs_assist || i_other_flush ||
     (i_snoop_hit_done_load && i_older_load_pending)))
    |=> o_count == $past(o_count) + 1)
    else $error("any-cause flush not counted");
  chk_order_flush: assert property (@(posedge i_mclk) // [RL12]
    disable iff (!rst_n)
    (i_snoop_hit_done_load && !i_older_load_pending) |=> !o_replay_from_load)
    else $error("ordering replay without older load");
  chk_order_replay: assert property (@(posedge i_mclk) // [RL11]
    disable iff (!rst_n)
    (i_snoop_hit_done_load && i_older_load_pending) |=>
      (o_replay_from_load && o_flush))
    else $error("ordering replay missing");
  chk_any_flush: assert property (@(posedge i_mclk) // [RL6] [RL5]
    disable iff (!rst_n)
    (i_fp_needs_assist || i_other_flush) |=> o_flush)
    else $error("flush missing");
  chk_flush_cause: assert property (@(posedge i_mclk) // [RL6]
    disable iff (!rst_n)
    o_flush |-> $past(i_store_valid || i_snoop_hit_done_load ||
      i_fp_needs_assist || i_other_flush))
    else $error("flush with no cause");
  chk_drain_entry: assert property (@(posedge i_mclk) // [RL9]
    disable iff (!rst_n)
    (fl_state_r == pmon_pkg::FL_IDLE && code_write_hazard) |=>
      fl_state_r == pmon_pkg::FL_DRAIN)
    else $error("code write flush did not drain");
  chk_drain_hold: assert property (@(posedge i_mclk) // [RL9]
    disable iff (!rst_n)
    (fl_state_r == pmon_pkg::FL_DRAIN && i_stores_pending) |=>
      (!o_frontend_restart && fl_state_r == pmon_pkg::FL_DRAIN))
    else $error("front end restarted with stores pending");
  chk_drain_restart: assert property (@(posedge i_mclk) // [RL9]
    disable iff (!rst_n)
    o_frontend_restart |-> !$past(i_stores_pending))
    else $error("restart before stores drained");
  chk_fp_assist: assert property (@(posedge i_mclk) // [RL10]
    disable iff (!rst_n)
    (fl_state_r == pmon_pkg::FL_IDLE && i_fp_needs_assist &&
     !code_write_hazard) |=> ##1 o_assist_fetch)
    else $error("assist fetch missing");
  chk_assist_pulse: assert property (@(posedge i_mclk) // [RL10]
    disable iff (!rst_n)
    o_assist_fetch |=> !o_assist_fetch)
    else $error("assist fetch longer than one cycle");
  chk_branch_all: assert property (@(posedge i_mclk) // [RL13]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_BR_ALL) |=> o_count == $past(o_count) +
      48'($countones($past(i_br_valid))))
    else $error("branch count wrong");
  chk_branch_jcc: assert property (@(posedge i_mclk) // [RL14]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_BR_JCC) |=> o_count == $past(o_count) +
      48'($countones($past(i_br_valid & i_br_cond))))
    else $error("conditional jump count wrong");
  chk_branch_far: assert property (@(posedge i_mclk) // [RL15]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_BR_FAR) |=> o_count == $past(o_count) +
      48'($countones($past(i_br_valid & i_br_far))))
    else $error("far branch count wrong");
  chk_branch_ind: assert property (@(posedge i_mclk) // [RL16]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_BR_IND && (i_br_valid & i_br_near_ind &
     ~i_br_return) == '0) |=> o_count == $past(o_count))
    else $error("indirect count moved");
  chk_branch_ind_count: assert property (@(posedge i_mclk) // [RL16]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_BR_IND) |=> o_count == $past(o_count) +
      48'($countones($past(i_br_valid & i_br_near_ind & ~i_br_return))))
    else $error("indirect branch count wrong");
  chk_none_holds: assert property (@(posedge i_mclk) // [RL18]
    disable iff (!rst_n)
    (sel == pmon_pkg::SEL_NONE) |=> $stable(o_count))
    else $error("counter moved with no event");
  chk_count_step: assert property (@(posedge i_mclk) // [RL17]
    disable iff (!rst_n)
    o_count - $past(o_count) <= 48'(`RET_LANES))
    else $error("counter stepped past lane count");

endmodule : retire_flush_event_counter
`default_nettype wire

// *** test/testbench.sv ***
// self-checking bench for the event qualifier and flush sequencer
`timescale 1ns/1ps
`include "pmon_cfg.svh"
`default_nettype none
module testbench;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_evt_code = 8'h00;
  logic [7:0] i_evt_mask = 8'h00;
  logic [`RET_LANES-1:0] i_uop_valid = '0, i_uop_from_rom = '0;
  logic [`RET_LANES-1:0] i_br_valid = '0, i_br_cond = '0, i_br_far = '0;
  logic [`RET_LANES-1:0] i_br_near_ind = '0, i_br_return = '0;
  logic i_store_valid = 1'b0, i_fetch_active = 1'b0, i_stores_pending = 1'b0;
  logic [`ADDR_W-1:0] i_store_addr = '0, i_fetch_addr = '0;
  logic i_snoop_hit_done_load = 1'b0, i_older_load_pending = 1'b0;
  logic i_fp_needs_assist = 1'b0, i_other_flush = 1'b0;
  logic o_flush, o_frontend_restart, o_assist_fetch, o_replay_from_load;
  logic [`CNT_W-1:0] o_count;
  int miscompares = 0;
  int checks = 0;
  int cyc = 0;
  longint model = 0;
  logic [15:0] sels [14] = '{16'hc201, 16'hc210, 16'hc301, 16'hc302,
    16'hc304, 16'hc308, 16'hc400, 16'hc47e, 16'hc4bf, 16'hc4eb,
    16'hc401, 16'hc200, 16'hc310, 16'h0000};

  retire_flush_event_counter retire_flush_event_counter_i (
    .i_mclk, .i_rst_n, .i_evt_code, .i_evt_mask, .i_uop_valid,
    .i_uop_from_rom, .i_br_valid, .i_br_cond, .i_br_far, .i_br_near_ind,
    .i_br_return, .i_store_valid, .i_store_addr, .i_fetch_active,
    .i_fetch_addr, .i_stores_pending, .i_snoop_hit_done_load,
    .i_older_load_pending, .i_fp_needs_assist, .i_other_flush, .o_flush,
    .o_frontend_restart, .o_assist_fetch, .o_replay_from_load, .o_count
  );

  initial begin
    forever #12.5 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares = miscompares + 1;
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////
  function automatic int pc(input logic [3:0] v);
    pc = v[0] + v[1] + v[2] + v[3];
  endfunction : pc

  // what the current inputs add at the edge that samples them
  function automatic int contrib();
    int cw;
    int mo;
    cw = i_store_valid && i_fetch_active &&
      i_store_addr[31:10] == i_fetch_addr[31:10];
    mo = i_snoop_hit_done_load && i_older_load_pending;
    case ({i_evt_code, i_evt_mask})
      16'hc201: contrib = pc(i_uop_valid & i_uop_from_rom);
      16'hc210: contrib = pc(i_uop_valid);
      16'hc301: contrib = cw;
      16'hc302: contrib = mo;
      16'hc304: contrib = i_fp_needs_assist;
      16'hc308: contrib = cw | mo | i_fp_needs_assist | i_other_flush;
      16'hc400: contrib = pc(i_br_valid);
      16'hc47e: contrib = pc(i_br_valid & i_br_cond);
      16'hc4bf: contrib = pc(i_br_valid & i_br_far);
      16'hc4eb: contrib = pc(i_br_valid & i_br_near_ind & ~i_br_return);
      default: contrib = 0;
    endcase
  endfunction : contrib

  task automatic chk(input string what, input logic [47:0] e,
      input logic [47:0] g);
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // mode 0 idles the event inputs, 1 randomises them, 2 leaves them
  task automatic step(input logic [15:0] s, input int mode);
    @(posedge i_mclk);
    model = model + contrib();
    i_evt_code <= s[15:8];
    i_evt_mask <= s[7:0];
    if (mode < 2) begin
      i_uop_valid <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_uop_from_rom <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_br_valid <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_br_cond <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_br_far <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_br_near_ind <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_br_return <= mode ? 4'($urandom_range(15)) : 4'h0;
      i_store_valid <= mode ? 1'($urandom_range(1)) : 1'b0;
      i_store_addr <= mode ? 32'($urandom_range(32'h2fff)) : 32'h0;
      i_fetch_active <= mode != 0;
      i_fetch_addr <= 32'h00001400;
      i_snoop_hit_done_load <= mode ? 1'($urandom_range(1)) : 1'b0;
      i_older_load_pending <= mode ? 1'($urandom_range(1)) : 1'b0;
      i_fp_needs_assist <= mode ? ($urandom_range(7) == 0) : 1'b0;
      i_other_flush <= mode ? ($urandom_range(7) == 0) : 1'b0;
    end
  endtask : step

  // flags in order flush, restart, assist, replay
  task automatic flg(input logic [3:0] e);
    @(negedge i_mclk);
    chk("flags", 48'(e), 48'({o_flush, o_frontend_restart, o_assist_fetch,
      o_replay_from_load}));
  endtask : flg

  task automatic burst(input logic [15:0] s, input int n);
    repeat (n) begin
      step(s, 1);
      @(negedge i_mclk);
      chk("count", model[47:0], o_count);
    end
    repeat (3) step(s, 0);
    @(negedge i_mclk);
    chk("count", model[47:0], o_count);
  endtask : burst

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8ad55df6));
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) step(16'hc308, 0);
    foreach (sels[k]) burst(sels[k], 40);
    step(16'hc308, 2);
    i_fp_needs_assist <= 1'b1;
    step(16'hc308, 0);
    flg(4'b1000);
    step(16'hc308, 0);
    flg(4'b0010);
    step(16'hc308, 2);
    i_snoop_hit_done_load <= 1'b1;
    i_older_load_pending <= 1'b1;
    step(16'hc308, 0);
    flg(4'b1001);
    step(16'hc308, 2);
    i_snoop_hit_done_load <= 1'b1;
    step(16'hc308, 0);
    flg(4'b0000);
    step(16'hc308, 2);
    i_fetch_active <= 1'b1;
    i_fetch_addr <= 32'h00001400;
    i_store_valid <= 1'b1;
    i_store_addr <= 32'h00001800;
    step(16'hc308, 0);
    flg(4'b0000);
    step(16'hc308, 2);
    i_fetch_active <= 1'b1;
    i_fetch_addr <= 32'h00001400;
    i_store_valid <= 1'b1;
    i_store_addr <= 32'h000017fc;
    i_stores_pending <= 1'b1;
    step(16'hc308, 0);
    flg(4'b1000);
    repeat (3) begin
      step(16'hc308, 2);
      flg(4'b0000);
    end
    step(16'hc308, 2);
    i_stores_pending <= 1'b0;
    // restart is registered at the edge that first sees the pipe empty
    step(16'hc308, 0);
    flg(4'b0100);
    step(16'hc308, 0);
    flg(4'b0000);
    repeat (3) step(16'hc308, 0);
    @(negedge i_mclk);
    chk("count", model[47:0], o_count);
    // second reset in mid-run: outputs clear, counting restarts from zero
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    model = 0;
    flg(4'b0000);
    chk("reset count", 48'h0, o_count);
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (4) step(16'hc210, 0);
    burst(16'hc210, 20);
    summarize();
  end
endmodule : testbench
`default_nettype wire
